// *** serial_bus_unit.sv ***
`timescale 1ns/1ps
module serial_bus_unit
	import serial_bus_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic RESET_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [31:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output logic SCK_OUT,
	output logic SCK_OE_OUT,
	output logic SO_OUT,
	output logic SO_OE_OUT,
	input wire logic SI_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_OUT,
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE_OUT
);
	import serial_bus_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	logic [1:0] rst_sync;
	logic rst_n;
	logic [1:0] si_meta, sda_meta, scl_meta;
	logic si_sync, sda_sync, scl_sync;

	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Pins are asynchronous to CLOCK_IN; only the second stage is read
	always_ff @(posedge CLOCK_IN or negedge rst_n) begin
		if (!rst_n) begin
			si_meta <= 2'h3;
			sda_meta <= 2'h3;
			scl_meta <= 2'h3;
		end else begin
			si_meta <= {si_meta[0], SI_IN};
			sda_meta <= {sda_meta[0], SDA_IN};
			scl_meta <= {scl_meta[0], SCL_IN};
		end
	end
	assign si_sync = si_meta[1];
	assign sda_sync = sda_meta[1];
	assign scl_sync = scl_meta[1];

	////////////////////////////////////////////////////////////////////////////////
	// Register file
	logic [2:0] bit_count, next_bit_count;
	logic ack_en, next_ack_en;
	logic [2:0] rate, next_rate;
	mode_e mode, next_mode;
	logic srst_armed, next_srst_armed;
	logic [3:0] srst_cnt, next_srst_cnt;
	logic [31:0] rdata, next_rdata;
	logic rx_valid, next_rx_valid;
	logic [7:0] rx_data, next_rx_data;
	logic last_ack, next_last_ack;
	logic setup, access, done, sel_ctl1, sel_ctl2, sel_data, sel_stat, mapped;
	logic in_ready, out_valid, pop, srst_busy, rx_done, engine_idle;
	logic [7:0] rx_shift;
	logic ack_sample;
	tx_word_s wr_word, out_word;

	assign setup = PSEL_IN && !PENABLE_IN;
	assign access = PSEL_IN && PENABLE_IN;
	assign sel_ctl1 = (PADDR_IN == CTRL_ONE_ADDR);
	assign sel_ctl2 = (PADDR_IN == CTRL_TWO_ADDR);
	assign sel_data = (PADDR_IN == DATA_ADDR);
	assign sel_stat = (PADDR_IN == STATUS_ADDR);
	assign mapped = sel_ctl1 || sel_ctl2 || sel_data || sel_stat;
	assign srst_busy = (srst_cnt != 4'h0);
	// Data writes stall the bus while the buffer is full, so no word is lost
	assign PREADY_OUT = !(access && PWRITE_IN && sel_data && !in_ready);
	assign PSLVERR_OUT = access && !mapped;
	assign done = access && PREADY_OUT;
	assign PRDATA_OUT = rdata;
	assign wr_word = '{stop: PWDATA_IN[DATA_STOP_BIT], start: PWDATA_IN[DATA_START_BIT],
		data: PWDATA_IN[7:0]};

	always_comb begin
		next_bit_count = bit_count;
		next_ack_en = ack_en;
		next_rate = rate;
		next_mode = mode;
		next_srst_armed = srst_armed;
		next_srst_cnt = srst_busy ? srst_cnt - 4'h1 : srst_cnt;
		next_rdata = rdata;
		next_rx_valid = rx_valid;
		next_rx_data = rx_data;
		next_last_ack = last_ack;
		if (setup && !PWRITE_IN) begin
			next_rdata = 32'h00000000;
			if (sel_ctl1) begin
				next_rdata[CR1_COUNT_LSB +: 3] = bit_count;
				next_rdata[CR1_ACK_BIT] = ack_en;
				next_rdata[CR1_RATE_LSB +: 3] = rate;
				next_rdata[CR1_MONITOR_BIT] = !srst_busy;
			end else if (sel_ctl2) begin
				next_rdata[CR2_MODE_LSB +: 2] = mode;
			end else if (sel_data) begin
				next_rdata[7:0] = rx_data;
			end else if (sel_stat) begin
				next_rdata[STAT_BUSY_BIT] = !engine_idle || out_valid;
				next_rdata[STAT_RX_VALID_BIT] = rx_valid;
				next_rdata[STAT_ACK_BIT] = last_ack;
				next_rdata[STAT_FULL_BIT] = !in_ready;
			end
		end
		if (done && !PWRITE_IN && sel_data) begin
			next_rx_valid = 1'b0;
		end
		if (done && PWRITE_IN && sel_ctl1) begin
			next_bit_count = PWDATA_IN[CR1_COUNT_LSB +: 3];
			next_ack_en = PWDATA_IN[CR1_ACK_BIT];
			next_rate = PWDATA_IN[CR1_RATE_LSB +: 3];
		end
		if (done && PWRITE_IN && sel_ctl2) begin
			next_mode = mode_e'(PWDATA_IN[CR2_MODE_LSB +: 2]);
			// Reset needs the two key codes in order
			if (PWDATA_IN[CR2_SRST_LSB +: 2] == SRST_KEY_SECOND && srst_armed) begin
				next_srst_cnt = SRST_CYCLES;
			end
			next_srst_armed = (PWDATA_IN[CR2_SRST_LSB +: 2] == SRST_KEY_FIRST);
		end
		// A finished frame wins over a read that clears the flag
		if (rx_done) begin
			next_rx_valid = 1'b1;
			next_rx_data = rx_shift;
		end
		if (ack_sample) begin
			next_last_ack = sda_sync;
		end
		if (srst_busy) begin
			next_rx_valid = 1'b0;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge rst_n) begin
		if (!rst_n) begin
			bit_count <= COUNT_RESET;
			ack_en <= RESET_ACK;
			rate <= RATE_RESET;
			mode <= MODE_PORT;
			srst_armed <= 1'b0;
			srst_cnt <= 4'h0;
			rdata <= 32'h00000000;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			last_ack <= 1'b0;
		end else begin
			bit_count <= next_bit_count;
			ack_en <= next_ack_en;
			rate <= next_rate;
			mode <= next_mode;
			srst_armed <= next_srst_armed;
			srst_cnt <= next_srst_cnt;
			rdata <= next_rdata;
			rx_valid <= next_rx_valid;
			rx_data <= next_rx_data;
			last_ack <= next_last_ack;
		end
	end

	tx_word_buffer u_buffer (
		.clk(CLOCK_IN),
		.rst_n(rst_n),
		.flush(srst_busy),
		.in_valid(done && PWRITE_IN && sel_data),
		.in_ready(in_ready),
		.in_word(wr_word),
		.out_valid(out_valid),
		.out_ready(pop),
		.out_word(out_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Shift engine
	engine_e state, next_state;
	logic [10:0] cnt, next_cnt;
	logic [10:0] half;
	logic [7:0] sreg, next_sreg;
	logic [7:0] rx_sreg, next_rx_sreg;
	logic [3:0] bits_left, next_bits_left;
	logic ack_slot, next_ack_slot;
	logic stop_after, next_stop_after;
	logic clk_low, next_clk_low;
	logic dat_low, next_dat_low;
	logic phase_end, stretch, in_ack, active;
	logic [2:0] rate_eff;

	assign active = (mode == MODE_SHIFT) || (mode == MODE_I2C);
	assign engine_idle = (state == ST_IDLE);
	assign rate_eff = (rate == RATE_RESERVED) ? RATE_SLOWEST : rate;
	// Shift amount is widened first, since code plus offset overflows three bits
	assign half = (11'h001 << ({1'b0, rate_eff} + 4'(RATE_EXP_OFFSET))) + HALF_EXTRA;
	// SCL held low by another master stretches the high phase
	assign stretch = (mode == MODE_I2C) && !scl_sync && !clk_low;
	assign phase_end = (cnt == half - 11'h001) && !stretch;
	assign in_ack = ack_slot && (bits_left == 4'h1);
	assign pop = engine_idle && out_valid && active && !srst_busy;
	assign rx_shift = rx_sreg;

	always_comb begin
		next_state = state;
		next_cnt = (phase_end || engine_idle) ? 11'h000 : (stretch ? cnt : cnt + 11'h001);
		next_sreg = sreg;
		next_rx_sreg = rx_sreg;
		next_bits_left = bits_left;
		next_ack_slot = ack_slot;
		next_stop_after = stop_after;
		rx_done = 1'b0;
		ack_sample = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (pop) begin
					next_sreg = out_word.data;
					next_rx_sreg = 8'h00;
					next_ack_slot = ack_en && (mode == MODE_I2C);
					next_bits_left = ((bit_count == COUNT_FULL_BYTE) ? BITS_PER_BYTE
						: {1'b0, bit_count}) + {3'h0, next_ack_slot};
					next_stop_after = out_word.stop && (mode == MODE_I2C);
					// Start ahead of a word also gives the repeated start
					next_state = (out_word.start && mode == MODE_I2C) ? ST_START : ST_BIT_LO;
				end
			end
			ST_START: begin
				if (phase_end) begin
					next_state = ST_BIT_LO;
				end
			end
			ST_BIT_LO: begin
				if (phase_end) begin
					next_state = ST_BIT_HI;
				end
			end
			ST_BIT_HI: begin
				if (phase_end) begin
					if (in_ack) begin
						ack_sample = 1'b1;
					end else begin
						next_rx_sreg = {rx_sreg[6:0], (mode == MODE_I2C) ? sda_sync : si_sync};
						next_sreg = {sreg[6:0], 1'b1};
					end
					next_bits_left = bits_left - 4'h1;
					if (bits_left == 4'h1) begin
						rx_done = 1'b1;
						next_state = stop_after ? ST_STOP_LO : ST_IDLE;
					end else begin
						next_state = ST_BIT_LO;
					end
				end
			end
			ST_STOP_LO: begin
				if (phase_end) begin
					next_state = ST_STOP_HI;
				end
			end
			ST_STOP_HI: begin
				if (phase_end) begin
					next_state = ST_IDLE;
				end
			end
		endcase
		if (rx_done && ack_sample) begin
			next_rx_sreg = rx_sreg;
		end
		if (srst_busy) begin
			next_state = ST_IDLE;
		end
		// Pin drive follows the next state so the pins change with it
		next_clk_low = (next_state == ST_BIT_LO) || (next_state == ST_STOP_LO);
		next_dat_low = (next_state == ST_START) || (next_state == ST_STOP_LO)
			|| (next_state == ST_STOP_HI)
			|| ((next_state == ST_BIT_LO || next_state == ST_BIT_HI)
				&& !(next_ack_slot && next_bits_left == 4'h1) && !next_sreg[7]);
	end

	always_ff @(posedge CLOCK_IN or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			cnt <= 11'h000;
			sreg <= 8'hFF;
			rx_sreg <= 8'h00;
			bits_left <= 4'h0;
			ack_slot <= 1'b0;
			stop_after <= 1'b0;
			clk_low <= 1'b0;
			dat_low <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			sreg <= next_sreg;
			rx_sreg <= next_rx_sreg;
			bits_left <= next_bits_left;
			ack_slot <= next_ack_slot;
			stop_after <= next_stop_after;
			clk_low <= next_clk_low;
			dat_low <= next_dat_low;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pins: port mode leaves every driver off
	assign SCK_OUT = !clk_low;
	assign SCK_OE_OUT = (mode == MODE_SHIFT);
	assign SO_OUT = !dat_low;
	assign SO_OE_OUT = (mode == MODE_SHIFT);
	assign SDA_OUT = 1'b0;
	assign SDA_OE_OUT = (mode == MODE_I2C) && dat_low;
	assign SCL_OUT = 1'b0;
	assign SCL_OE_OUT = (mode == MODE_I2C) && clk_low;
endmodule : serial_bus_unit

// *** serial_bus_pkg.sv ***
package serial_bus_pkg;

	// Register byte addresses on the APB bus
	localparam logic [31:0] CTRL_ONE_ADDR = 32'hFFFFF240;
	localparam logic [31:0] CTRL_TWO_ADDR = 32'hFFFFF244;
	localparam logic [31:0] DATA_ADDR = 32'hFFFFF248;
	localparam logic [31:0] STATUS_ADDR = 32'hFFFFF24C;

	// Control register one fields
	localparam int CR1_COUNT_LSB = 5;
	localparam int CR1_ACK_BIT = 4;
	localparam int CR1_RATE_LSB = 0;
	localparam int CR1_MONITOR_BIT = 0;
	localparam logic [2:0] COUNT_RESET = 3'h0;
	localparam logic RESET_ACK = 1'b0;
	localparam logic [2:0] RATE_RESET = 3'h0;
	localparam logic [2:0] RATE_RESERVED = 3'h7;
	localparam logic [2:0] RATE_SLOWEST = 3'h6;
	localparam logic [2:0] COUNT_FULL_BYTE = 3'h0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Control register two fields
	localparam int CR2_MODE_LSB = 2;
	localparam int CR2_SRST_LSB = 0;
	localparam logic [1:0] SRST_KEY_FIRST = 2'h2;
	localparam logic [1:0] SRST_KEY_SECOND = 2'h1;
	localparam logic [3:0] SRST_CYCLES = 4'h8;

	// Data register fields on write
	localparam int DATA_START_BIT = 8;
	localparam int DATA_STOP_BIT = 9;

	// Status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RX_VALID_BIT = 1;
	localparam int STAT_ACK_BIT = 2;
	localparam int STAT_FULL_BIT = 3;

	// Half SCL period is (2^n + 4) / 2 = 2^(n-1) + 2 cycles, n = code + 4
	localparam int RATE_EXP_OFFSET = 3;
	localparam logic [10:0] HALF_EXTRA = 11'h002;

	typedef enum logic [1:0] {
		MODE_PORT = 2'h0,
		MODE_SHIFT = 2'h1,
		MODE_I2C = 2'h2,
		MODE_RSVD = 2'h3
	} mode_e;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_START = 6'h02,
		ST_BIT_LO = 6'h04,
		ST_BIT_HI = 6'h08,
		ST_STOP_LO = 6'h10,
		ST_STOP_HI = 6'h20
	} engine_e;

	typedef struct packed {
		logic stop;
		logic start;
		logic [7:0] data;
	} tx_word_s;

endpackage : serial_bus_pkg

// *** tx_word_buffer.sv ***
`timescale 1ns/1ps
module tx_word_buffer
	import serial_bus_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input serial_bus_pkg::tx_word_s in_word,
	output logic out_valid,
	input wire logic out_ready,
	output serial_bus_pkg::tx_word_s out_word
);
	tx_word_s slot0;
	tx_word_s slot1;
	logic [1:0] count;
	tx_word_s next_slot0;
	tx_word_s next_slot1;
	logic [1:0] next_count;
	logic push;
	logic pop;

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_word = slot0;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_slot0 = slot0;
		next_slot1 = slot1;
		next_count = count;
		if (flush) begin
			next_count = 2'h0;
		end else begin
			if (pop) begin
				next_slot0 = slot1;
			end
			if (push) begin
				if (count == 2'h0 || (pop && count == 2'h1)) begin
					next_slot0 = in_word;
				end else begin
					next_slot1 = in_word;
				end
			end
			next_count = count + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot0 <= '0;
			slot1 <= '0;
			count <= 2'h0;
		end else begin
			slot0 <= next_slot0;
			slot1 <= next_slot1;
			count <= next_count;
		end
	end
endmodule : tx_word_buffer

// *** serial_bus_checker.sv ***
`timescale 1ns/1ps
module serial_bus_checker
	import serial_bus_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic RESET_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [31:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic SCK_OE_OUT,
	input wire logic SO_OE_OUT,
	input wire logic SDA_OUT,
	input wire logic SDA_OE_OUT,
	input wire logic SCL_OUT,
	input wire logic SCL_OE_OUT
);
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RESET_N_IN);
	logic acc;
	logic mapped;
	logic rd_one;
	logic key_one;
	logic [3:0] sr_cnt;
	logic [2:0] rate;
	int lo_cnt;
	int half;
	assign acc = PSEL_IN && PENABLE_IN;
	assign rd_one = acc && !PWRITE_IN && PADDR_IN == CTRL_ONE_ADDR;
	assign mapped = PADDR_IN inside {CTRL_ONE_ADDR, CTRL_TWO_ADDR, DATA_ADDR, STATUS_ADDR};
	// Reserved rate code runs as the slowest one
	assign half = (8 << ((rate == RATE_RESERVED) ? 6 : rate)) + 2;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			sr_cnt <= 4'hF;
			rate <= 3'h0;
			key_one <= 1'b0;
			lo_cnt <= 0;
		end else begin
			lo_cnt <= SCL_OE_OUT ? lo_cnt + 1 : 0;
			if (sr_cnt != 4'hF) begin
				sr_cnt <= sr_cnt + 4'h1;
			end
			if (acc && PREADY_OUT && PWRITE_IN && PADDR_IN == CTRL_ONE_ADDR) begin
				rate <= PWDATA_IN[2:0];
			end
			if (acc && PREADY_OUT && PWRITE_IN && PADDR_IN == CTRL_TWO_ADDR) begin
				key_one <= PWDATA_IN[1:0] == SRST_KEY_FIRST;
				if (key_one && PWDATA_IN[1:0] == SRST_KEY_SECOND) begin
					sr_cnt <= 4'h1;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////
	AST_UNMAPPED_ERR: assert property (acc && !mapped |-> PSLVERR_OUT && (PWRITE_IN || PRDATA_OUT == 32'h0))
		else $error("unmapped access not refused");
	AST_MAPPED_OK: assert property (acc && mapped |-> !PSLVERR_OUT)
		else $error("mapped access flagged");
	AST_ZERO_WAIT: assert property (acc && !(PWRITE_IN && PADDR_IN == DATA_ADDR) |-> PREADY_OUT)
		else $error("register access delayed");
	AST_OPEN_DRAIN: assert property (SDA_OUT == 1'b0 && SCL_OUT == 1'b0)
		else $error("bus line driven high");
	AST_SHIFT_PINS: assert property (SO_OE_OUT == SCK_OE_OUT)
		else $error("shift pins enabled apart");
	AST_MODES_APART: assert property (SO_OE_OUT |-> !SDA_OE_OUT && !SCL_OE_OUT)
		else $error("two modes drive at once");
	AST_SRST_BUSY: assert property (rd_one && sr_cnt inside {[4'h2:4'h6]} |-> !PRDATA_OUT[0])
		else $error("monitor misses soft reset");
	AST_SRST_DONE: assert property (rd_one && sr_cnt == 4'hF |-> PRDATA_OUT[0])
		else $error("monitor stuck in reset");
	AST_SCL_HALF: assert property ($fell(SCL_OE_OUT) |-> lo_cnt == half)
		else $error("clock low half wrong length");
endmodule : serial_bus_checker

bind serial_bus_unit serial_bus_checker chk (.CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN),
	.PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
	.PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .SCK_OE_OUT(SCK_OE_OUT), .SO_OE_OUT(SO_OE_OUT),
	.SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .SCL_OUT(SCL_OUT), .SCL_OE_OUT(SCL_OE_OUT));

// *** bus_partner.sv ***
`timescale 1ns/1ps
module bus_partner (
	input wire logic scl_oe_in,
	input wire logic sda_oe_in,
	input wire logic sck_in,
	input wire logic so_in,
	input wire logic ack_in,
	input wire logic [3:0] nbits_in,
	input wire logic [7:0] pat_in,
	output logic scl_out,
	output logic sda_out,
	output logic si_out,
	output logic [7:0] word_out,
	output logic [7:0] sword_out
);
	int cnt = 0;
	int k = 0;
	int j = 0;
	logic pull = 1'b0;
	logic [7:0] sh;
	// Released lines float high through their pull-ups
	assign scl_out = !scl_oe_in;
	assign sda_out = !(sda_oe_in || pull);
	// Look just after the edge: SCL falling in the same step is no start
	always @(negedge sda_out) #1 if (scl_out) cnt = 0;
	always @(posedge scl_out) begin
		sh = {sh[6:0], sda_out};
		cnt++;
		if (cnt == nbits_in) word_out = sh;
	end
	// Acknowledge held over the whole slot after the last data bit
	always @(negedge scl_out) pull <= ack_in && cnt == nbits_in;
	always @(posedge sck_in) begin
		sword_out = {sword_out[6:0], so_in};
		k++;
	end
	// New bit only after the falling edge, so it stands through the high half
	always @(negedge sck_in) j = k;
	assign si_out = pat_in[7 - j % 8];
endmodule : bus_partner

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_fail++; \
	$display("BAD %s exp %h got %h", nm, ex, gt); end end
module testbench;
	import serial_bus_pkg::*;
	logic clk = 0;
	logic rst_n = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [31:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata, r;
	logic pready, pslverr, err, sck, sck_oe, so, so_oe, si, sda, sda_oe, scl, scl_oe, scl_d;
	logic ack_on = 0;
	logic [3:0] nb = 0;
	logic [7:0] d, pat = 0, word, sword;
	int n_fail = 0, checked = 0, cyc = 0, runs = 0, waits;
	serial_bus_unit dut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SCK_OUT(sck),
		.SCK_OE_OUT(sck_oe), .SO_OUT(so), .SO_OE_OUT(so_oe), .SI_IN(si), .SDA_IN(sda),
		.SDA_OUT(), .SDA_OE_OUT(sda_oe), .SCL_IN(scl), .SCL_OUT(), .SCL_OE_OUT(scl_oe));
	// Released shift pins float high, so no clock reaches the partner outside shift mode
	bus_partner far (.scl_oe_in(scl_oe), .sda_oe_in(sda_oe), .sck_in(sck || !sck_oe),
		.so_in(so || !so_oe),
		.ack_in(ack_on), .nbits_in(nb), .pat_in(pat), .scl_out(scl), .sda_out(sda),
		.si_out(si), .word_out(word), .sword_out(sword));
	initial forever #20 clk = !clk;
	////////////////////////////////////////////////////////////////
	task give_verdict;
		if (n_fail == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	// All frames take about 25k cycles, so this only trips on a hang
	always @(posedge clk) begin
		cyc <= cyc + 1;
		scl_d <= scl_oe;
		if (scl_d && !scl_oe) runs++;
		if (cyc == 60000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		waits = -1;
		do begin
			@(posedge clk);
			waits++;
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic idle;
		repeat (4) @(posedge clk);
		do apb(0, STATUS_ADDR, 0); while (r[STAT_BUSY_BIT] !== 1'b0);
	endtask : idle
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hCACAF40D));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		apb(0, CTRL_ONE_ADDR, 0);
		`CHK("cr1 reset", 3'h1, r[2:0])
		apb(0, CTRL_ONE_ADDR + 32'h10, 0);
		`CHK("unmapped", 33'h1_0000_0000, {err, r})
		// Port mode holds words in the buffer without sending them
		apb(1, DATA_ADDR, 32'h300 | $urandom % 256);
		apb(1, DATA_ADDR, 32'h300 | $urandom % 256);
		apb(0, STATUS_ADDR, 0);
		`CHK("full", 1'b1, r[STAT_FULL_BIT])
		apb(1, CTRL_TWO_ADDR, 32'h8);
		// One word leaves at once, so one write fills it again and the next write stalls
		apb(1, DATA_ADDR, 32'h3A5);
		apb(1, DATA_ADDR, 32'h35A);
		`CHK("stall", 1'b1, waits > 0)
		idle();
		for (int i = 0; i < 8; i++) begin
			nb = (i == 0) ? 4'h8 : 4'(i);
			ack_on = i[0];
			apb(1, CTRL_ONE_ADDR, {24'h0, i[2:0], i[0], 1'b0, i[2:0]});
			d = 8'($urandom);
			runs = 0;
			apb(1, DATA_ADDR, {22'h0, 2'h3, d});
			idle();
			`CHK("clocks", nb + ack_on + 1, runs)
			`CHK("word", d >> (8 - nb), word & ((9'h1 << nb) - 1))
			if (ack_on) `CHK("ack", 1'b0, r[STAT_ACK_BIT])
		end
		apb(1, CTRL_TWO_ADDR, 32'hA);
		apb(1, CTRL_TWO_ADDR, 32'h9);
		apb(0, CTRL_ONE_ADDR, 0);
		`CHK("monitor busy", 1'b0, r[CR1_MONITOR_BIT])
		repeat (12) @(posedge clk);
		apb(0, CTRL_ONE_ADDR, 0);
		`CHK("monitor done", 1'b1, r[CR1_MONITOR_BIT])
		apb(1, CTRL_ONE_ADDR, 0);
		apb(1, CTRL_TWO_ADDR, 32'h4);
		pat = 8'($urandom);
		d = 8'($urandom);
		apb(1, DATA_ADDR, {24'h0, d});
		idle();
		`CHK("rx valid", 1'b1, r[STAT_RX_VALID_BIT])
		`CHK("shift out", d, sword)
		apb(0, DATA_ADDR, 0);
		`CHK("shift in", pat, r[7:0])
		apb(0, STATUS_ADDR, 0);
		`CHK("rx cleared", 1'b0, r[STAT_RX_VALID_BIT])
		give_verdict();
	end
endmodule : testbench
